// >>> rtl/cce_exec.v
// execution core for file clear, work clear, watchdog clear and call
// assumes one instruction word per clk_sys from same-clock fetch logic,
// presented with instr_valid and belonging to address pc_out;
// wdog_timeout_evt comes from the watchdog's own oscillator
`timescale 1ns/100ps
`include "cce_defs.vh"

module cce_exec (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire [13:0] instr_word,
    input  wire        instr_valid,
    input  wire        wdog_timeout_evt,
    input  wire        sleep_evt,
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output wire [12:0] pc_out,
    output wire        fetch_flush,
    output reg  [6:0]  file_addr,
    output reg  [7:0]  file_wdata,
    output reg         file_we,
    output reg         stack_push,
    output reg  [12:0] top_of_stack,
    output reg         watchdog_counter_clr,
    output reg         prescaler_clr,
    output wire        zero_flag,
    output wire        timeout_flag,
    output wire        powerdown_flag,
    output wire [7:0]  working_reg
);

    localparam ST_EXEC  = 1'b0;
    localparam ST_CALL2 = 1'b1;

    reg        state_r;
    reg        state_nxt;
    reg [12:0] pc_r;
    reg [7:0]  work_r;
    reg        zero_r;
    reg        tmout_r;
    reg        pwrdn_r;
    reg        run_en_r;
    reg [7:0]  latch_r;
    reg [7:0]  retired_r;
    reg        wdog_s1_r;
    reg        wdog_s2_r;
    reg        wdog_s3_r;
    reg        wdog_lvl_r;

    wire       is_clear_file;
    wire       is_clear_work;
    wire       is_clear_wdog;
    wire       is_call;
    wire [12:0] pc_nxt;
    wire [12:0] ret_addr;
    wire       wdog_evt_sync;
    wire       wr_ctrl;
    wire       wr_latch;
    wire       wr_status;
    wire       wr_work;
    wire       wr_retired;

    // a word executes only in the first-cycle state while running
    wire       exec_slot;
    wire       do_clear_file;
    wire       do_clear_work;
    wire       do_clear_wdog;
    wire       do_call;

    assign exec_slot     = instr_valid & run_en_r & (state_r == ST_EXEC);
    assign do_clear_file = exec_slot & is_clear_file;
    assign do_clear_work = exec_slot & is_clear_work;
    assign do_clear_wdog = exec_slot & is_clear_wdog;
    assign do_call       = exec_slot & is_call;

    // register port write to one offset
    function wr_hit;
        input       wr;
        input [2:0] addr;
        input [2:0] offset;
        begin
            wr_hit = wr & (addr == offset);
        end
    endfunction

    assign wr_ctrl    = wr_hit(reg_wr, reg_addr, `CCE_REG_CTRL);
    assign wr_latch   = wr_hit(reg_wr, reg_addr, `CCE_REG_LATCH);
    assign wr_status  = wr_hit(reg_wr, reg_addr, `CCE_REG_STATUS);
    assign wr_work    = wr_hit(reg_wr, reg_addr, `CCE_REG_WORK);
    assign wr_retired = wr_hit(reg_wr, reg_addr, `CCE_REG_RETIRED);

    cce_decode u_decode (
        .instr_word    (instr_word),
        .is_clear_file (is_clear_file),
        .is_clear_work (is_clear_work),
        .is_clear_wdog (is_clear_wdog),
        .is_call       (is_call)
    );

    cce_pcgen u_pcgen (
        .pc_cur              (pc_r),
        .instr_word          (instr_word),
        .upper_address_latch (latch_r),
        .take_call           (do_call),
        .advance             (exec_slot),
        .pc_next             (pc_nxt),
        .return_addr         (ret_addr)
    );

    // call occupies two cycles; the second executes nothing
    always @* begin
        case (state_r)
            ST_EXEC: begin
                if (do_call) begin
                    state_nxt = ST_CALL2;
                end else begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_CALL2: begin
                state_nxt = ST_EXEC;
            end
            default: begin
                state_nxt = ST_EXEC;
            end
        endcase
    end

    // flush while the word fetched behind the call is on the port
    assign fetch_flush = (state_r == ST_CALL2);

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_EXEC;
            pc_r    <= `CCE_PC_RST;
        end else begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
        end
    end

    // register file side: file clear drives a one-cycle zero write
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            file_addr  <= 7'h00;
            file_wdata <= 8'h00;
            file_we    <= 1'b0;
        end else begin
            file_we    <= do_clear_file;
            file_wdata <= 8'h00;
            if (do_clear_file) begin
                file_addr <= instr_word[`CCE_FADDR_MSB:0];
            end
        end
    end

    // stack side: return address goes out with a one-cycle push
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stack_push   <= 1'b0;
            top_of_stack <= `CCE_PC_RST;
        end else begin
            stack_push <= do_call;
            if (do_call) begin
                top_of_stack <= ret_addr;
            end
        end
    end

    // watchdog side: timer and prescaler cleared together
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_counter_clr <= 1'b0;
            prescaler_clr        <= 1'b0;
        end else begin
            watchdog_counter_clr <= do_clear_wdog;
            prescaler_clr        <= do_clear_wdog;
        end
    end

    // working register
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            work_r <= `CCE_WORK_RST;
        end else if (do_clear_work) begin
            work_r <= 8'h00;
        end else if (wr_work) begin
            work_r <= reg_wdata;
        end
    end

    // zero flag: file and work clears set it, software may write it, watchdog clear and call leave it
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            zero_r <= 1'b0;
        end else if (do_clear_file || do_clear_work) begin
            zero_r <= 1'b1;
        end else if (wr_status) begin
            zero_r <= reg_wdata[`CCE_ST_ZERO];
        end
    end

    // three stages; a change counts once stages two and three agree
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wdog_s1_r  <= 1'b0;
            wdog_s2_r  <= 1'b0;
            wdog_s3_r  <= 1'b0;
            wdog_lvl_r <= 1'b0;
        end else begin
            wdog_s1_r <= wdog_timeout_evt;
            wdog_s2_r <= wdog_s1_r;
            wdog_s3_r <= wdog_s2_r;
            if (wdog_s2_r == wdog_s3_r) begin
                wdog_lvl_r <= wdog_s3_r;
            end
        end
    end

    // one-cycle event on an accepted rising change
    assign wdog_evt_sync = wdog_s2_r & wdog_s3_r & ~wdog_lvl_r;

    // timeout flag: watchdog clear sets, a timeout clears;
    // the set wins when both land in one cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tmout_r <= `CCE_FLAG_RST;
        end else if (do_clear_wdog) begin
            tmout_r <= 1'b1;
        end else if (wdog_evt_sync) begin
            tmout_r <= 1'b0;
        end
    end

    // power-down flag: watchdog clear sets, sleep clears, set wins
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pwrdn_r <= `CCE_FLAG_RST;
        end else if (do_clear_wdog) begin
            pwrdn_r <= 1'b1;
        end else if (sleep_evt) begin
            pwrdn_r <= 1'b0;
        end
    end

    // control and latch registers written over the register port
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_en_r <= `CCE_CTRL_RST;
            latch_r  <= `CCE_LATCH_RST;
        end else begin
            if (wr_ctrl) begin
                run_en_r <= reg_wdata[0];
            end
            if (wr_latch) begin
                latch_r <= reg_wdata;
            end
        end
    end

    // retired count: a call retires once, after its no-operation cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            retired_r <= 8'h00;
        end else if (wr_retired) begin
            retired_r <= 8'h00;
        end else if ((exec_slot && !is_call) || state_r == ST_CALL2) begin
            retired_r <= retired_r + 8'h01;
        end
    end

    // read data stands one cycle after the read strobe, zero otherwise
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCE_REG_CTRL:    reg_rdata <= {7'h00, run_en_r};
                `CCE_REG_LATCH:   reg_rdata <= latch_r;
                `CCE_REG_STATUS:  reg_rdata <= {3'h0, tmout_r, pwrdn_r, 2'h0, zero_r};
                `CCE_REG_PC_LO:   reg_rdata <= pc_r[7:0];
                `CCE_REG_PC_HI:   reg_rdata <= {3'h0, pc_r[12:8]};
                `CCE_REG_WORK:    reg_rdata <= work_r;
                `CCE_REG_RETIRED: reg_rdata <= retired_r;
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign pc_out         = pc_r;
    assign zero_flag      = zero_r;
    assign timeout_flag   = tmout_r;
    assign powerdown_flag = pwrdn_r;
    assign working_reg    = work_r;

endmodule

// >>> include/cce_defs.vh
// constants for the clear-and-call execution block
// included by every rtl file of the block
`ifndef CCE_DEFS_VH
`define CCE_DEFS_VH

// opcode patterns, 14-bit instruction word
`define CCE_OP_CLRFILE_MASK  14'h3f80
`define CCE_OP_CLRFILE_VAL   14'h0180
`define CCE_OP_CLRWORK       14'h0103
`define CCE_OP_CLRWDOG       14'h0064
`define CCE_OP_CALL_MASK     14'h3800
`define CCE_OP_CALL_VAL      14'h2000

// field positions
`define CCE_FADDR_MSB        6
`define CCE_TARGET_MSB       10
`define CCE_LATCH_HI         4
`define CCE_LATCH_LO         3
`define CCE_PC_W             13

// register port offsets
`define CCE_REG_CTRL         3'h0
`define CCE_REG_LATCH        3'h1
`define CCE_REG_STATUS       3'h2
`define CCE_REG_PC_LO        3'h3
`define CCE_REG_PC_HI        3'h4
`define CCE_REG_WORK         3'h5
`define CCE_REG_RETIRED      3'h6

// status register bit positions
`define CCE_ST_ZERO          0
`define CCE_ST_PWRDN         3
`define CCE_ST_TMOUT         4

// reset values
`define CCE_CTRL_RST         1'b1
`define CCE_LATCH_RST        8'h00
`define CCE_WORK_RST         8'h00
`define CCE_PC_RST           13'h0000
`define CCE_FLAG_RST         1'b1

// cycle counts
`define CCE_CALL_CYCLES      2
`define CCE_SINGLE_CYCLES    1

`endif

// >>> rtl/cce_decode.v
// opcode classifier for the clear and call instructions
// pure combinational, instruction word comes from same-clock fetch logic
`timescale 1ns/100ps
`include "cce_defs.vh"

module cce_decode (
    input  wire [13:0] instr_word,
    output wire        is_clear_file,
    output wire        is_clear_work,
    output wire        is_clear_wdog,
    output wire        is_call
);

    function match;
        input [13:0] word;
        input [13:0] mask;
        input [13:0] val;
        begin
            match = ((word & mask) == val);
        end
    endfunction

    assign is_clear_file = match(instr_word, `CCE_OP_CLRFILE_MASK, `CCE_OP_CLRFILE_VAL);
    assign is_clear_work = match(instr_word, 14'h3fff, `CCE_OP_CLRWORK);
    assign is_clear_wdog = match(instr_word, 14'h3fff, `CCE_OP_CLRWDOG);
    assign is_call       = match(instr_word, `CCE_OP_CALL_MASK, `CCE_OP_CALL_VAL);

endmodule

// >>> rtl/cce_pcgen.v
// next program counter and return address for the executing word
// combinational; caller registers the results
`timescale 1ns/100ps
`include "cce_defs.vh"

module cce_pcgen (
    input  wire [12:0] pc_cur,
    input  wire [13:0] instr_word,
    input  wire [7:0]  upper_address_latch,
    input  wire        take_call,
    input  wire        advance,
    output reg  [12:0] pc_next,
    output wire [12:0] return_addr
);

    assign return_addr = pc_cur + 13'h0001;

    always @* begin
        if (take_call) begin
            // upper two bits from the latch, low eleven from the word
            pc_next = {upper_address_latch[`CCE_LATCH_HI:`CCE_LATCH_LO],
                       instr_word[`CCE_TARGET_MSB:0]};
        end else if (advance) begin
            pc_next = return_addr;
        end else begin
            pc_next = pc_cur;
        end
    end

endmodule

// >>> bench/cce_exec_properties.sv
// concurrent checks on the ports of the clear and call execution core
// bound to cce_exec; register writes mirrored for run enable and latch
`timescale 1ns/100ps
module cce_exec_properties (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire [13:0] instr_word,
    input wire        instr_valid,
    input wire        wdog_timeout_evt,
    input wire        sleep_evt,
    input wire [2:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire [12:0] pc_out,
    input wire        fetch_flush,
    input wire [6:0]  file_addr,
    input wire [7:0]  file_wdata,
    input wire        file_we,
    input wire        stack_push,
    input wire [12:0] top_of_stack,
    input wire        watchdog_counter_clr,
    input wire        prescaler_clr,
    input wire        zero_flag,
    input wire        timeout_flag,
    input wire        powerdown_flag,
    input wire [7:0]  working_reg
);
    reg       en_r;
    reg [1:0] lat_r;
    wire      tk = instr_valid && en_r && !fetch_flush;
    wire      cl = tk && instr_word[13:11] == 3'h4;
    wire      wd = tk && instr_word == 14'h0064;
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= 1'b1;
            lat_r <= 2'h0;
        end else if (reg_wr && reg_addr == 3'h0) begin
            en_r <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 3'h1) begin
            lat_r <= reg_wdata[4:3];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // push cycle with flush, then target cycle with pc held
    sequence call_tail_s;
        (fetch_flush && stack_push) ##1 (!fetch_flush && !stack_push && $stable(pc_out));
    endsequence
    file_clr_a: assert property (
        tk && instr_word[13:7] == 7'h03 |=> file_we && zero_flag && file_wdata == 8'h00
        && file_addr == $past(instr_word[6:0])) else $error("file clear wrong");
    call_push_a: assert property (
        cl |=> top_of_stack == $past(pc_out) + 13'h0001) else $error("return address wrong");
    call_low_a: assert property (
        cl |=> pc_out[10:0] == $past(instr_word[10:0])) else $error("call target wrong");
    call_high_a: assert property (
        cl |=> pc_out[12:11] == $past(lat_r)) else $error("call upper bits wrong");
    call_flags_a: assert property (
        cl |=> $stable(zero_flag) && $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("call touched flags");
    call_noop_a: assert property (
        cl |=> call_tail_s) else $error("call second cycle wrong");
    work_clr_a: assert property (
        tk && instr_word == 14'h0103 |=> working_reg == 8'h00 && zero_flag)
        else $error("work clear wrong");
    wdog_clr_a: assert property (
        wd |=> watchdog_counter_clr && prescaler_clr) else $error("watchdog clear missing");
    wdog_flags_a: assert property (
        wd |=> timeout_flag && powerdown_flag && $stable(zero_flag))
        else $error("watchdog flags wrong");
    clr_pair_a: assert property (
        watchdog_counter_clr == $past(wd) && prescaler_clr == $past(wd))
        else $error("clear pulse wrong");
endmodule
bind cce_exec cce_exec_properties u_chk (.*);

// >>> bench/clear_and_call_instr_exec_test.sv
// self-checking bench for the clear and call execution core
// drives every input itself at rising edges; no far-side model
`timescale 1ns/100ps
module clear_and_call_instr_exec_test;
    reg         clk_sys = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [13:0] instr_word = 14'h0000;
    reg         instr_valid = 1'b0;
    reg         wdog_timeout_evt = 1'b0;
    reg         sleep_evt = 1'b0;
    reg  [2:0]  reg_addr = 3'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [7:0]  reg_rdata;
    wire [12:0] pc_out;
    wire        fetch_flush;
    wire [6:0]  file_addr;
    wire [7:0]  file_wdata;
    wire        file_we;
    wire        stack_push;
    wire [12:0] top_of_stack;
    wire        watchdog_counter_clr;
    wire        prescaler_clr;
    wire        zero_flag;
    wire        timeout_flag;
    wire        powerdown_flag;
    wire [7:0]  working_reg;
    integer     num_errors = 0;
    integer     checked = 0;
    cce_exec DUT (.*);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
            @(posedge clk_sys) reg_wr <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge clk_sys) reg_rd <= 1'b0;
            #1 chk(reg_rdata, e);
        end
    endtask
    task ex(input [13:0] w);
        begin
            @(posedge clk_sys) {instr_valid, instr_word} <= {1'b1, w};
            @(posedge clk_sys) instr_valid <= 1'b0;
            #1;
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #200000;
        num_errors = num_errors + 1;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 chk({timeout_flag, powerdown_flag, zero_flag, pc_out}, 16'hc000);
        rd(3'h2, 8'h18);
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h01);
        $display("reset test done");
        ex(14'h01ff);
        chk({file_we, file_addr, file_wdata}, 16'hff00);
        chk({zero_flag, pc_out}, 16'h2001);
        wr(3'h5, 8'h5a);
        rd(3'h5, 8'h5a);
        ex(14'h0103);
        chk({zero_flag, working_reg}, 16'h0100);
        $display("clear test done");
        @(posedge clk_sys) {wdog_timeout_evt, sleep_evt} <= 2'h3;
        @(posedge clk_sys) sleep_evt <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({timeout_flag, powerdown_flag}, 16'h0002);
        @(posedge clk_sys) wdog_timeout_evt <= 1'b0;
        #1 chk({timeout_flag, powerdown_flag}, 16'h0000);
        ex(14'h0064);
        chk({watchdog_counter_clr, prescaler_clr}, 16'h0003);
        chk({timeout_flag, powerdown_flag, zero_flag}, 16'h0007);
        @(posedge clk_sys) #1 chk({watchdog_counter_clr, prescaler_clr}, 16'h0000);
        $display("watchdog test done");
        wr(3'h1, 8'h18);
        wr(3'h5, 8'h3c);
        @(posedge clk_sys) {instr_valid, instr_word} <= {1'b1, 14'h27ff};
        @(posedge clk_sys) instr_word <= 14'h0103;
        #1 chk(pc_out, 16'h1fff);
        chk(top_of_stack, 16'h0004);
        chk({stack_push, fetch_flush}, 16'h0003);
        @(posedge clk_sys) instr_valid <= 1'b0;
        #1 chk({zero_flag, working_reg}, 16'h013c);
        chk({stack_push, fetch_flush, pc_out}, 16'h1fff);
        rd(3'h3, 8'hff);
        rd(3'h4, 8'h1f);
        wr(3'h1, 8'h00);
        ex(14'h2000);
        chk({pc_out, top_of_stack[2:0]}, 16'h0000);
        chk(top_of_stack, 16'h0000);
        $display("call test done");
        wr(3'h2, 8'h00);
        wr(3'h0, 8'h00);
        ex(14'h0103);
        chk({zero_flag, working_reg}, 16'h003c);
        chk(pc_out, 16'h0000);
        wr(3'h0, 8'h01);
        @(posedge clk_sys) {instr_valid, instr_word, sleep_evt} <= {1'b1, 14'h0064, 1'b1};
        @(posedge clk_sys) {instr_valid, sleep_evt} <= 2'h0;
        #1 chk({powerdown_flag, pc_out}, 16'h2001);
        rd(3'h2, 8'h18);
        rd(3'h6, 8'h06);
        wr(3'h6, 8'h00);
        rd(3'h6, 8'h00);
        $display("control test done");
        give_verdict;
    end
endmodule
